// ==== uvp_cfg.svh ====
`ifndef UVP_CFG_SVH
`define UVP_CFG_SVH
`define UVP_OFS_CTRL     8'h00
`define UVP_OFS_GROUP    8'h04
`define UVP_OFS_PU0      8'h08
`define UVP_OFS_BLK0     8'h0C
`define UVP_OFS_PU1      8'h10
`define UVP_OFS_BLK1     8'h14
`define UVP_OFS_VTPRI    8'h18
`define UVP_OFS_STATUS   8'h1C
`define UVP_OFS_RAT_A    8'h20
`define UVP_OFS_RAT_B    8'h24
`define UVP_OFS_RAT_C    8'h28
`define UVP_OFS_RAT_MIN  8'h2C
`define UVP_OFS_PU_PRI   8'h30
`define UVP_OFS_BLK_PRI  8'h34
`define UVP_OFS_EXP_T    8'h38
`define UVP_OFS_REM_T    8'h3C
`define UVP_CTRL_SEL_LSB 0
`define UVP_CTRL_TWO_LN  2
`define UVP_CTRL_FRC_EN  3
`define UVP_CTRL_FRC_LSB 4
`define UVP_CTRL_RST     6'h00
`define UVP_PU_RST       16'h1770
`define UVP_BLK_RST      16'h03E8
`define UVP_PU_MAX       16'h2EE0
`define UVP_BLK_MAX      16'h2710
`define UVP_VTPRI_RST    24'h0003E8
`define UVP_HYST_NUM     24'h000067
`define UVP_RATIO_SCALE  24'h000064
`define UVP_RATIO_MAX    17'h1E848
`define UVP_PCT_DEN      40'h0000002710
`endif

// ==== uvp_pkg.sv ====
package uvp_pkg;
    typedef enum logic [3:0] {
        UVP_ST_NORMAL  = 4'h1,
        UVP_ST_START   = 4'h2,
        UVP_ST_TRIP    = 4'h4,
        UVP_ST_BLOCKED = 4'h8
    } uvp_status_t;
    typedef enum logic [1:0] {
        UVP_MAG_PP  = 2'h0,
        UVP_MAG_PE  = 2'h1,
        UVP_MAG_CH3 = 2'h2,
        UVP_MAG_CH4 = 2'h3
    } uvp_mag_t;
    typedef logic [15:0] uvp_volt_t;
    typedef logic [16:0] uvp_ratio_t;
endpackage : uvp_pkg

// ==== uvp_stage.sv ====
`timescale 1ns/100ps
`include "uvp_cfg.svh"
module uvp_stage
    import uvp_pkg::*;
(
    input  wire logic        SYS_CLK_IN,
    input  wire logic        NRST_IN,
    input  wire logic [7:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    input  wire logic        TICK_IN,
    input  wire logic [15:0] U_L12_IN,
    input  wire logic [15:0] U_L23_IN,
    input  wire logic [15:0] U_L31_IN,
    input  wire logic [15:0] U_L1_IN,
    input  wire logic [15:0] U_L2_IN,
    input  wire logic [15:0] U_L3_IN,
    input  wire logic [15:0] U_CH3_IN,
    input  wire logic [15:0] U_CH4_IN,
    input  wire logic        EXT_BLOCK_IN,
    input  wire logic        TRIP_REQ_IN,
    input  wire logic [18:0] EXP_TIME_IN,
    input  wire logic [19:0] REMAIN_TIME_IN,
    output logic             PICKUP_OUT,
    output logic             START_OUT,
    output logic             TRIP_OUT,
    output logic             BLOCKED_OUT,
    output logic             LV_BLOCK_OUT
);

    function automatic logic above_hyst(input uvp_volt_t u, input uvp_volt_t s);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = {8'h00, u} * `UVP_RATIO_SCALE;
        rhs = {8'h00, s} * `UVP_HYST_NUM;
        return lhs > rhs;
    endfunction : above_hyst
    function automatic uvp_ratio_t ratio(input uvp_volt_t u, input uvp_volt_t s);
        logic [23:0] num;
        logic [23:0] q;
        num = {8'h00, u} * `UVP_RATIO_SCALE;
        q   = (s == 16'h0000) ? {7'h00, `UVP_RATIO_MAX} : num / {8'h00, s};
        return (q > {7'h00, `UVP_RATIO_MAX}) ? `UVP_RATIO_MAX : q[16:0];
    endfunction : ratio
    function automatic logic [23:0] primary(input uvp_volt_t s, input logic [23:0] vt);
        logic [39:0] p;
        p = {24'h000000, s} * {16'h0000, vt};
        p = p / `UVP_PCT_DEN;
        return p[23:0];
    endfunction : primary
    function automatic uvp_volt_t wr_clamp(input uvp_volt_t old, input uvp_volt_t lim);
        logic [31:0] m;
        m = {16'h0000, old};
        for (int b = 0; b < 4; b++) begin
            if (AVS_BYTEENABLE_IN[b]) begin
                m[b*8 +: 8] = AVS_WRITEDATA_IN[b*8 +: 8];
            end
        end
        return (m > {16'h0000, lim}) ? lim : m[15:0];
    endfunction : wr_clamp

    // bus slave
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_c;
    logic        wr_en;
    assign wr_en = AVS_WRITE_IN && !wait_q;

    // general settings stay outside the group banks
    logic [5:0]  ctrl_q;
    logic        group_q;
    uvp_volt_t   pu_q [2];
    uvp_volt_t   blk_q [2];
    logic [23:0] vtpri_q;

    // evaluation state
    logic [2:0]  pk_q;
    logic [2:0]  pk_d;
    logic        lv_q;
    logic        lv_d;
    logic        ext_q;
    logic        frc_q;
    logic        pickup_q;
    logic        start_q;
    logic        trip_q;
    logic        blocked_q;
    uvp_ratio_t  rat_q [3];
    uvp_ratio_t  rat_min_q;
    logic [23:0] pu_pri_q;
    logic [23:0] blk_pri_q;
    logic [18:0] exp_t_q;
    logic [19:0] rem_t_q;

    uvp_mag_t    mag;
    logic        two_line;
    uvp_volt_t   pu_act;
    uvp_volt_t   blk_act;
    uvp_volt_t   sel_u [3];
    logic [2:0]  sup;
    logic        low_any;
    logic        all_above;
    uvp_volt_t   u_min;
    uvp_status_t st_d;

    assign mag      = uvp_mag_t'(ctrl_q[`UVP_CTRL_SEL_LSB +: 2]);
    assign two_line = ctrl_q[`UVP_CTRL_TWO_LN];
    // banked levels switch instantly; supervision state is kept
    assign pu_act   = pu_q[group_q];
    assign blk_act  = blk_q[group_q];

    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            wait_q <= 1'b1;
        end else if (wait_q && (AVS_READ_IN || AVS_WRITE_IN)) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_comb begin
        rdata_c = 32'h00000000;
        unique case (AVS_ADDRESS_IN)
            `UVP_OFS_CTRL:    rdata_c = {26'h0000000, ctrl_q};
            `UVP_OFS_GROUP:   rdata_c = {31'h00000000, group_q};
            `UVP_OFS_PU0:     rdata_c = {16'h0000, pu_q[0]};
            `UVP_OFS_BLK0:    rdata_c = {16'h0000, blk_q[0]};
            `UVP_OFS_PU1:     rdata_c = {16'h0000, pu_q[1]};
            `UVP_OFS_BLK1:    rdata_c = {16'h0000, blk_q[1]};
            `UVP_OFS_VTPRI:   rdata_c = {8'h00, vtpri_q};
            `UVP_OFS_STATUS:  rdata_c = {25'h0000000, frc_q, ext_q, lv_q,
                                         blocked_q, trip_q, start_q, pickup_q};
            `UVP_OFS_RAT_A:   rdata_c = {15'h0000, rat_q[0]};
            `UVP_OFS_RAT_B:   rdata_c = {15'h0000, rat_q[1]};
            `UVP_OFS_RAT_C:   rdata_c = {15'h0000, rat_q[2]};
            `UVP_OFS_RAT_MIN: rdata_c = {15'h0000, rat_min_q};
            `UVP_OFS_PU_PRI:  rdata_c = {8'h00, pu_pri_q};
            `UVP_OFS_BLK_PRI: rdata_c = {8'h00, blk_pri_q};
            `UVP_OFS_EXP_T:   rdata_c = {13'h0000, exp_t_q};
            `UVP_OFS_REM_T:   rdata_c = {{12{rem_t_q[19]}}, rem_t_q};
            default:          rdata_c = 32'h00000000;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rdata_q <= 32'h00000000;
        end else if (AVS_READ_IN && wait_q) begin
            rdata_q <= rdata_c;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ctrl_q  <= `UVP_CTRL_RST;
            group_q <= 1'b0;
            vtpri_q <= `UVP_VTPRI_RST;
        end else if (wr_en) begin
            if (AVS_ADDRESS_IN == `UVP_OFS_CTRL && AVS_BYTEENABLE_IN[0]) begin
                ctrl_q <= AVS_WRITEDATA_IN[5:0];
            end
            if (AVS_ADDRESS_IN == `UVP_OFS_GROUP && AVS_BYTEENABLE_IN[0]) begin
                group_q <= AVS_WRITEDATA_IN[0];
            end
            if (AVS_ADDRESS_IN == `UVP_OFS_VTPRI) begin
                for (int b = 0; b < 3; b++) begin
                    if (AVS_BYTEENABLE_IN[b]) begin
                        vtpri_q[b*8 +: 8] <= AVS_WRITEDATA_IN[b*8 +: 8];
                    end
                end
            end
        end
    end

    // out-of-range writes saturate rather than wrap
    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pu_q[0]  <= `UVP_PU_RST;
            pu_q[1]  <= `UVP_PU_RST;
            blk_q[0] <= `UVP_BLK_RST;
            blk_q[1] <= `UVP_BLK_RST;
        end else if (wr_en) begin
            unique case (AVS_ADDRESS_IN)
                `UVP_OFS_PU0:  pu_q[0]  <= wr_clamp(pu_q[0], `UVP_PU_MAX);
                `UVP_OFS_PU1:  pu_q[1]  <= wr_clamp(pu_q[1], `UVP_PU_MAX);
                `UVP_OFS_BLK0: blk_q[0] <= wr_clamp(blk_q[0], `UVP_BLK_MAX);
                `UVP_OFS_BLK1: blk_q[1] <= wr_clamp(blk_q[1], `UVP_BLK_MAX);
                default: ;
            endcase
        end
    end

    always_comb begin
        sel_u[0] = U_L12_IN;
        sel_u[1] = U_L23_IN;
        sel_u[2] = U_L31_IN;
        sup      = two_line ? 3'h3 : 3'h7;
        unique case (mag)
            UVP_MAG_PP: ;
            UVP_MAG_PE: begin
                sel_u[0] = U_L1_IN;
                sel_u[1] = U_L2_IN;
                sel_u[2] = U_L3_IN;
            end
            UVP_MAG_CH3: begin
                sel_u[0] = U_CH3_IN;
                sup      = two_line ? 3'h1 : 3'h0;
            end
            UVP_MAG_CH4: begin
                sel_u[0] = U_CH4_IN;
                sup      = 3'h1;
            end
        endcase
    end

    always_comb begin
        low_any   = 1'b0;
        all_above = (sup != 3'h0);
        u_min     = 16'hFFFF;
        for (int i = 0; i < 3; i++) begin
            pk_d[i] = pk_q[i];
            if (!sup[i]) begin
                pk_d[i] = 1'b0;
            end else if (sel_u[i] < pu_act) begin
                pk_d[i] = 1'b1;
            end else if (above_hyst(sel_u[i], pu_act)) begin
                pk_d[i] = 1'b0;
            end
            if (sup[i]) begin
                low_any   = low_any || (sel_u[i] < blk_act);
                all_above = all_above && (sel_u[i] > pu_act);
                u_min     = (sel_u[i] < u_min) ? sel_u[i] : u_min;
            end
        end
        // a fresh low reading beats recovery in the same tick
        lv_d = lv_q;
        if (blk_act == 16'h0000) begin
            lv_d = 1'b0;
        end else if (low_any) begin
            lv_d = 1'b1;
        end else if (all_above) begin
            lv_d = 1'b0;
        end
    end

    always_comb begin
        st_d = UVP_ST_NORMAL;
        if (ctrl_q[`UVP_CTRL_FRC_EN]) begin
            unique case (ctrl_q[`UVP_CTRL_FRC_LSB +: 2])
                2'h0: st_d = UVP_ST_NORMAL;
                2'h1: st_d = UVP_ST_START;
                2'h2: st_d = UVP_ST_TRIP;
                2'h3: st_d = UVP_ST_BLOCKED;
            endcase
        end else if (|pk_d) begin
            if (EXT_BLOCK_IN) begin
                st_d = UVP_ST_BLOCKED;
            end else if (TRIP_REQ_IN && !lv_d) begin
                st_d = UVP_ST_TRIP;
            end else begin
                st_d = UVP_ST_START;
            end
        end
    end

    // all supervision updates land on the tick only
    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pk_q      <= 3'h0;
            lv_q      <= 1'b0;
            ext_q     <= 1'b0;
            frc_q     <= 1'b0;
            pickup_q  <= 1'b0;
            start_q   <= 1'b0;
            trip_q    <= 1'b0;
            blocked_q <= 1'b0;
        end else if (TICK_IN) begin
            pk_q      <= pk_d;
            lv_q      <= lv_d;
            ext_q     <= EXT_BLOCK_IN;
            frc_q     <= ctrl_q[`UVP_CTRL_FRC_EN];
            pickup_q  <= |pk_d;
            start_q   <= (st_d == UVP_ST_START) || (st_d == UVP_ST_TRIP);
            trip_q    <= (st_d == UVP_ST_TRIP);
            blocked_q <= (st_d == UVP_ST_BLOCKED);
        end
    end

    // the divider is combinational; fine at 25 MHz, costly in area
    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            for (int i = 0; i < 3; i++) begin
                rat_q[i] <= 17'h00000;
            end
            rat_min_q <= 17'h00000;
            pu_pri_q  <= 24'h000000;
            blk_pri_q <= 24'h000000;
            exp_t_q   <= 19'h00000;
            rem_t_q   <= 20'h00000;
        end else if (TICK_IN) begin
            for (int i = 0; i < 3; i++) begin
                rat_q[i] <= sup[i] ? ratio(sel_u[i], pu_act) : 17'h00000;
            end
            rat_min_q <= (sup != 3'h0) ? ratio(u_min, pu_act) : 17'h00000;
            pu_pri_q  <= primary(pu_act, vtpri_q);
            blk_pri_q <= primary(blk_act, vtpri_q);
            exp_t_q   <= EXP_TIME_IN;
            rem_t_q   <= REMAIN_TIME_IN;
        end
    end

    assign AVS_READDATA_OUT    = rdata_q;
    assign AVS_WAITREQUEST_OUT = wait_q;
    assign PICKUP_OUT          = pickup_q;
    assign START_OUT           = start_q;
    assign TRIP_OUT            = trip_q;
    assign BLOCKED_OUT         = blocked_q;
    assign LV_BLOCK_OUT        = lv_q;

    property p_trip_lv;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        TRIP_OUT && !frc_q |-> !LV_BLOCK_OUT;
    endproperty
    a_trip_lv: assert property (p_trip_lv) else $error("trip while low-voltage block");
    property p_ext_blk;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        TICK_IN && (|pk_d) && EXT_BLOCK_IN && !ctrl_q[3] |=> BLOCKED_OUT && !START_OUT;
    endproperty
    a_ext_blk: assert property (p_ext_blk) else $error("external block not honoured");
    property p_start;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        TICK_IN && (|pk_d) && !EXT_BLOCK_IN && !ctrl_q[3] |=> START_OUT && PICKUP_OUT;
    endproperty
    a_start: assert property (p_start) else $error("pick-up without start");
    property p_hyst;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        TICK_IN && sup[0] && pk_q[0] && !above_hyst(sel_u[0], pu_act) |=> pk_q[0];
    endproperty
    a_hyst: assert property (p_hyst) else $error("released inside hysteresis");
    property p_lv_hold;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        LV_BLOCK_OUT && !(TICK_IN && (all_above || blk_act == 16'h0000)) |=> LV_BLOCK_OUT;
    endproperty
    a_lv_hold: assert property (p_lv_hold) else $error("low-voltage block dropped early");
    property p_tick_only;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        !TICK_IN |=> $stable(rat_q[0]) && $stable(TRIP_OUT) && $stable(PICKUP_OUT);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("update between ticks");
    property p_force;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        TICK_IN && ctrl_q[3] && ctrl_q[5:4] == 2'h2 |=> TRIP_OUT && START_OUT && !BLOCKED_OUT;
    endproperty
    a_force: assert property (p_force) else $error("forced trip not shown");
    property p_ch3;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        TICK_IN && mag == UVP_MAG_CH3 && !two_line |=> !PICKUP_OUT;
    endproperty
    a_ch3: assert property (p_ch3) else $error("channel 3 used outside two-line mode");
    property p_pu_range;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        1'b1 |-> pu_q[0] <= `UVP_PU_MAX && pu_q[1] <= `UVP_PU_MAX && blk_q[0] <= `UVP_BLK_MAX;
    endproperty
    a_pu_range: assert property (p_pu_range) else $error("level out of range");
    property p_bus;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer late");
endmodule : uvp_stage

// ==== tb_top.sv ====
`timescale 1ns/100ps
`include "uvp_cfg.svh"
module tb_top
    import uvp_pkg::*;
;
    logic        SYS_CLK_IN = 1'b0;
    logic        NRST_IN = 1'b0;
    logic [7:0]  AVS_ADDRESS_IN = 8'h00;
    logic        AVS_READ_IN = 1'b0;
    logic        AVS_WRITE_IN = 1'b0;
    logic [31:0] AVS_WRITEDATA_IN = 32'h0;
    logic [3:0]  AVS_BYTEENABLE_IN = 4'hF;
    logic [31:0] AVS_READDATA_OUT;
    logic        AVS_WAITREQUEST_OUT;
    logic        TICK_IN = 1'b0;
    logic [15:0] U_L12_IN = 16'h2710;
    logic [15:0] U_L23_IN = 16'h2710;
    logic [15:0] U_L31_IN = 16'h2710;
    logic [15:0] U_L1_IN = 16'h2710;
    logic [15:0] U_L2_IN = 16'h2710;
    logic [15:0] U_L3_IN = 16'h2710;
    logic [15:0] U_CH3_IN = 16'h2710;
    logic [15:0] U_CH4_IN = 16'h2710;
    logic        EXT_BLOCK_IN = 1'b0;
    logic        TRIP_REQ_IN = 1'b0;
    logic [18:0] EXP_TIME_IN = 19'h0;
    logic [19:0] REMAIN_TIME_IN = 20'h0;
    logic        PICKUP_OUT;
    logic        START_OUT;
    logic        TRIP_OUT;
    logic        BLOCKED_OUT;
    logic        LV_BLOCK_OUT;
    logic [4:0]  flags;
    int          n_errors = 0;
    int          comparisons = 0;
    // case table for the magnitude selection: control word, low channel, pick-up expected
    logic [5:0]  sel_tab [0:5] = '{6'h00, 6'h04, 6'h01, 6'h02, 6'h06, 6'h03};
    logic [3:0]  low_tab [0:5] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h4, 4'h8};
    logic        exp_tab [0:5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

    assign flags = {LV_BLOCK_OUT, BLOCKED_OUT, TRIP_OUT, START_OUT, PICKUP_OUT};

    uvp_stage DUT (
        .SYS_CLK_IN(SYS_CLK_IN), .NRST_IN(NRST_IN),
        .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
        .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
        .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
        .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .TICK_IN(TICK_IN),
        .U_L12_IN(U_L12_IN), .U_L23_IN(U_L23_IN), .U_L31_IN(U_L31_IN),
        .U_L1_IN(U_L1_IN), .U_L2_IN(U_L2_IN), .U_L3_IN(U_L3_IN),
        .U_CH3_IN(U_CH3_IN), .U_CH4_IN(U_CH4_IN), .EXT_BLOCK_IN(EXT_BLOCK_IN),
        .TRIP_REQ_IN(TRIP_REQ_IN), .EXP_TIME_IN(EXP_TIME_IN),
        .REMAIN_TIME_IN(REMAIN_TIME_IN), .PICKUP_OUT(PICKUP_OUT), .START_OUT(START_OUT),
        .TRIP_OUT(TRIP_OUT), .BLOCKED_OUT(BLOCKED_OUT), .LV_BLOCK_OUT(LV_BLOCK_OUT)
    );

    initial begin
        forever #20 SYS_CLK_IN = ~SYS_CLK_IN;
    end

    task tally_and_finish;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // bounded wait: a slave that never answers ends the run instead of hanging it
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge SYS_CLK_IN);
        AVS_ADDRESS_IN   <= a;
        AVS_WRITEDATA_IN <= d;
        AVS_READ_IN      <= ~wr;
        AVS_WRITE_IN     <= wr;
        do begin
            @(posedge SYS_CLK_IN);
            n++;
        end while (AVS_WAITREQUEST_OUT !== 1'b0 && n < 50);
        if (AVS_WAITREQUEST_OUT !== 1'b0) begin
            n_errors++;
            $display("FAIL %0t bus answer never came", $time);
            tally_and_finish();
        end
        rd = AVS_READDATA_OUT;
        AVS_READ_IN  <= 1'b0;
        AVS_WRITE_IN <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        chk(v, exp);
    endtask : rdchk

    // flags are launched by the tick edge, so they are looked at just after it
    task automatic tick(input logic [15:0] u);
        @(posedge SYS_CLK_IN);
        U_L12_IN <= u;
        TICK_IN  <= 1'b1;
        @(posedge SYS_CLK_IN);
        TICK_IN  <= 1'b0;
        #1;
    endtask : tick

    task automatic chans(input logic [3:0] m);
        @(posedge SYS_CLK_IN);
        U_L31_IN <= m[0] ? 16'h1388 : 16'h2710;
        U_L3_IN  <= m[1] ? 16'h1388 : 16'h2710;
        U_CH3_IN <= m[2] ? 16'h1388 : 16'h2710;
        U_CH4_IN <= m[3] ? 16'h1388 : 16'h2710;
    endtask : chans

    initial begin
        repeat (12) @(posedge SYS_CLK_IN);
        NRST_IN <= 1'b1;
        @(posedge SYS_CLK_IN);
        chk({27'h0, flags}, 32'h0);
        rdchk(`UVP_OFS_CTRL, 32'h0);
        rdchk(`UVP_OFS_PU0, 32'h1770);
        rdchk(`UVP_OFS_BLK0, 32'h03E8);
        wr(8'h40, 32'h5A5A);
        rdchk(8'h40, 32'h0);
        tick(16'h0BB8);
        chk({27'h0, flags}, 32'h3);
        rdchk(`UVP_OFS_RAT_A, 32'h32);
        rdchk(`UVP_OFS_RAT_B, 32'hA6);
        rdchk(`UVP_OFS_RAT_C, 32'hA6);
        rdchk(`UVP_OFS_RAT_MIN, 32'h32);
        rdchk(`UVP_OFS_PU_PRI, 32'h258);
        rdchk(`UVP_OFS_BLK_PRI, 32'h64);
        rdchk(`UVP_OFS_STATUS, 32'h3);
        tick(16'h17D4);
        chk({27'h0, flags}, 32'h3);
        tick(16'h1824);
        chk({27'h0, flags}, 32'h3);
        tick(16'h1825);
        chk({27'h0, flags}, 32'h0);
        tick(16'h1770);
        chk({27'h0, flags}, 32'h0);
        @(posedge SYS_CLK_IN);
        U_L12_IN <= 16'h1388;
        repeat (3) @(posedge SYS_CLK_IN);
        #1;
        chk({27'h0, flags}, 32'h0);
        @(posedge SYS_CLK_IN);
        EXT_BLOCK_IN <= 1'b1;
        tick(16'h1388);
        chk({27'h0, flags}, 32'h9);
        rdchk(`UVP_OFS_STATUS, 32'h29);
        @(posedge SYS_CLK_IN);
        EXT_BLOCK_IN <= 1'b0;
        TRIP_REQ_IN  <= 1'b1;
        tick(16'h1388);
        chk({27'h0, flags}, 32'h7);
        tick(16'h01F4);
        chk({27'h0, flags}, 32'h13);
        tick(16'h157C);
        chk({27'h0, flags}, 32'h13);
        tick(16'h17D4);
        chk({27'h0, flags}, 32'h7);
        wr(`UVP_OFS_BLK0, 32'h0);
        tick(16'h01F4);
        chk({27'h0, flags}, 32'h7);
        wr(`UVP_OFS_BLK0, 32'h03E8);
        TRIP_REQ_IN <= 1'b0;
        tick(16'h2710);
        wr(`UVP_OFS_PU0, 32'h32C8);
        rdchk(`UVP_OFS_PU0, 32'h2EE0);
        AVS_BYTEENABLE_IN <= 4'h1;
        wr(`UVP_OFS_PU0, 32'hFFFFFF00);
        AVS_BYTEENABLE_IN <= 4'hF;
        rdchk(`UVP_OFS_PU0, 32'h2E00);
        wr(`UVP_OFS_PU0, 32'h1770);
        wr(`UVP_OFS_PU1, 32'h0FA0);
        wr(`UVP_OFS_GROUP, 32'h1);
        tick(16'h1388);
        chk({27'h0, flags}, 32'h0);
        wr(`UVP_OFS_GROUP, 32'h0);
        tick(16'h1388);
        chk({27'h0, flags}, 32'h3);
        tick(16'h2710);
        wr(`UVP_OFS_CTRL, 32'h28);
        tick(16'h2710);
        chk({30'h0, TRIP_OUT, PICKUP_OUT}, 32'h2);
        wr(`UVP_OFS_GROUP, 32'h1);
        rdchk(`UVP_OFS_CTRL, 32'h28);
        wr(`UVP_OFS_GROUP, 32'h0);
        wr(`UVP_OFS_CTRL, 32'h38);
        tick(16'h2710);
        chk({31'h0, BLOCKED_OUT}, 32'h1);
        wr(`UVP_OFS_CTRL, 32'h18);
        tick(16'h2710);
        chk({29'h0, TRIP_OUT, START_OUT, BLOCKED_OUT}, 32'h2);
        wr(`UVP_OFS_CTRL, 32'h08);
        TRIP_REQ_IN <= 1'b1;
        tick(16'h1388);
        chk({27'h0, flags}, 32'h1);
        wr(`UVP_OFS_CTRL, 32'h0);
        TRIP_REQ_IN <= 1'b0;
        tick(16'h2710);
        for (int i = 0; i < 6; i++) begin
            wr(`UVP_OFS_CTRL, {26'h0, sel_tab[i]});
            chans(low_tab[i]);
            tick(16'h2710);
            chk({31'h0, PICKUP_OUT}, {31'h0, exp_tab[i]});
            chans(4'h0);
            tick(16'h2710);
        end
        wr(`UVP_OFS_CTRL, 32'h0);
        @(posedge SYS_CLK_IN);
        EXP_TIME_IN    <= 19'h00123;
        REMAIN_TIME_IN <= 20'hFFFF6;
        tick(16'h2710);
        rdchk(`UVP_OFS_EXP_T, 32'h123);
        rdchk(`UVP_OFS_REM_T, 32'hFFFFFFF6);
        tally_and_finish();
    end
endmodule : tb_top
